/* File: logic/liu_diag_pkg.sv */
// Purpose: Shared constants and carriers for the channel diagnostic block
// Assumes: 250 MHz clock, one channel per instance
// Notes: Field positions follow the control byte layouts
package liu_diag_pkg;
  localparam int CLK_HZ = 250000000;
  localparam int SECOND_S = 1;
  localparam int SECOND_CYCLES = SECOND_S * CLK_HZ;
  localparam int AUTO_LOOP_MS = 5100;
  localparam int AUTO_LOOP_CYCLES = AUTO_LOOP_MS * (CLK_HZ / 1000) + 1;
  localparam int COUNT_W = 16;
  localparam int JIT_W = 16;
  localparam int MON_W = 6;
  localparam logic [2:0] SRC_LINE_BIPOLAR_VIOLATION = 3'h0;
  localparam logic [2:0] SRC_LINE_EXCESS_ZEROS = 3'h1;
  localparam logic [2:0] SRC_LBOTH = 3'h2;
  localparam logic [2:0] SRC_SYSTEM_BIPOLAR_VIOLATION = 3'h3;
  localparam logic [2:0] SRC_SYSTEM_EXCESS_ZEROS = 3'h4;
  localparam logic [2:0] SRC_SBOTH = 3'h5;
  localparam logic [2:0] SRC_PATT = 3'h6;
  localparam logic [COUNT_W-1:0] COUNT_ONES = 16'hFFFF;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 16'h0000;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 16'h0001;
  localparam logic [MON_W-1:0] MON_OFF = 6'h00;

  // Error control byte: bit 4..2 source, bit 1 mode, bit 0 snapshot trigger
  typedef struct packed {
    logic [2:0] countSourceSelect;
    logic countUpdateMode;
    logic countSnapshotTrigger;
  } err_ctrl_t;

  typedef struct packed {
    logic lineBipolarViolation;
    logic lineExcessZeros;
    logic systemBipolarViolation;
    logic systemExcessZeros;
    logic patternError;
  } err_events_t;

  // Loop control: bit 0 analog, bit 1 remote, bit 2 digital, bit 3 auto
  typedef struct packed {
    logic autoLoopEnable;
    logic digitalLoopEnable;
    logic remoteLoopEnable;
    logic analogLoopEnable;
  } loop_ctrl_t;

  // Jitter control: bit 2 trigger, bit 1 period mode, bit 0 bandwidth
  typedef struct packed {
    logic jitterSnapshotTrigger;
    logic jitterPeriodMode;
    logic jitterBandwidthSelect;
  } jit_ctrl_t;

  typedef struct packed {
    logic rxPatternWins;
    logic rxLoopData;
    logic rxAisAllowed;
    logic txPatternWins;
    logic txLoopData;
    logic txAisAllowed;
    logic txClockIgnored;
  } path_sel_t;
endpackage : liu_diag_pkg

/* File: logic/liu_second_timer.sv */
// Purpose: Free running one second tick from the master clock
// Assumes: Synchronous active low reset
// Notes: Emits a single cycle tick at each expiry
`timescale 1ns/1ps
module liu_second_timer #(
  parameter int PERIOD = liu_diag_pkg::SECOND_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  output logic tick
);
  import liu_diag_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic tick;
  } tmr_state_t;

  localparam logic [31:0] LAST = 32'(PERIOD - 1);

  tmr_state_t st;
  tmr_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (st.count == LAST) begin
      next_st.count = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.count = st.count + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick = st.tick;
endmodule : liu_second_timer

/* File: logic/liu_channel_diag.sv */
// Purpose: Per channel error counter, loopback selection and channel 0 jitter capture
// Assumes: Pin level inputs are synchronised here; detector pulses come from clk logic
// Notes: Loop outputs lag the automatic loop state by one clock
// Notes on behaviour
// - 16-bit counter counts the error source chosen by the three-bit select field
// - System BPV sources are not counted while transmit input is single rail NRZ
// - Mode bit one picks per-second snapshots, zero picks software snapshots
// - Second timer sets sticky tick status, cleared by write one, masked to interrupt
// - Automatic mode copies count to holding registers each second and restarts
// - Manual rising trigger copies count to holding registers and restarts the count
// - Error arriving with the counter at all ones sets overflow status, masked
// - Analog loop keeps transmit on line and feeds it into the receiver input
// - Analog loop forces remote and digital loopback off
// - Analog loop: receive pattern beats looped data, AIS off both ways
// - Remote loop from manual bit or auto bit with receive detection direction
// - Auto loop entered or left after code held over 5.1 s; state shown
// - Remote loop sends receive attenuator data to shaper, ignores transmit clock
// - Remote loop: receive pattern beats AIS, transmit pattern beats loop, no tx AIS
// - Digital loop from manual bit or auto bit with transmit detection direction
// - Digital loop feeds transmit attenuator into decoder; line monitors see real line
// - Digital loop: rx pattern beats loop; tx pattern, loop, then AIS; no rx AIS
// - Nonzero monitor select routes another channel into channel 0 with external match
// - Channel 0 captures greatest positive and negative jitter peaks when enabled
// - Jitter period is one second or a manual rising trigger; peaks moved, buffers cleared
`timescale 1ns/1ps
module liu_channel_diag #(
  parameter int SECOND_PERIOD = liu_diag_pkg::SECOND_CYCLES,
  parameter int AUTO_HOLD = liu_diag_pkg::AUTO_LOOP_CYCLES
) (
  input wire logic clk,
  input wire logic nrst,
  input wire liu_diag_pkg::err_ctrl_t errCtrl,
  input wire liu_diag_pkg::err_events_t errEvents,
  input wire logic txSingleRailNrz,
  input wire logic secondTickIntMask,
  input wire logic secondTickIntClear,
  input wire logic countOverflowIntMask,
  input wire logic countOverflowIntClear,
  input wire liu_diag_pkg::loop_ctrl_t loopCtrl,
  input wire logic detectDirection,
  input wire logic activateCodeSeen,
  input wire logic deactivateCodeSeen,
  input wire logic [liu_diag_pkg::MON_W-1:0] monitorSourceSelect,
  input wire logic isChannelZero,
  input wire logic receiveJitterAttenuatorOn,
  input wire liu_diag_pkg::jit_ctrl_t jitCtrl,
  input wire logic jitterSampleValid,
  input wire logic jitterSampleNegative,
  input wire logic [liu_diag_pkg::JIT_W-1:0] jitterSample,
  output logic [liu_diag_pkg::COUNT_W-1:0] errorCount,
  output logic secondTickIntStatus,
  output logic countOverflowIntStatus,
  output logic intOut,
  output logic autoLoopState,
  output logic analogLoopActive,
  output logic remoteLoopActive,
  output logic digitalLoopActive,
  output liu_diag_pkg::path_sel_t pathSel,
  output logic externalMatchForced,
  output logic monitorActive,
  output logic jitterBandwidth,
  output logic [liu_diag_pkg::JIT_W-1:0] jitterPosPeak,
  output logic [liu_diag_pkg::JIT_W-1:0] jitterNegPeak
);
  import liu_diag_pkg::*;

  typedef enum logic [2:0] {
    AL_IDLE = 3'b001,
    AL_REMOTE = 3'b010,
    AL_DIGITAL = 3'b100
  } auto_st_t;

  typedef struct packed {
    logic [1:0] actSync;
    logic [1:0] deactSync;
    logic [COUNT_W-1:0] counter;
    logic [COUNT_W-1:0] holding;
    logic tickStatus;
    logic ovfStatus;
    logic intOut;
    logic prevCountTrig;
    logic prevJitTrig;
    auto_st_t autoSt;
    logic autoActive;
    logic [31:0] holdCount;
    logic holdIsDeact;
    logic analog;
    logic remote;
    logic digital;
    path_sel_t path;
    logic extMatch;
    logic monActive;
    logic jitBw;
    logic [JIT_W-1:0] posBuf;
    logic [JIT_W-1:0] negBuf;
    logic [JIT_W-1:0] posPeak;
    logic [JIT_W-1:0] negPeak;
  } diag_state_t;

  localparam logic [31:0] HOLD_LAST = 32'(AUTO_HOLD - 1);

  diag_state_t st;
  diag_state_t next_st;
  logic secondTick;

  liu_second_timer #(.PERIOD(SECOND_PERIOD)) uTimer (
    .clk(clk),
    .nrst(nrst),
    .tick(secondTick)
  );

  function automatic logic errorSelected(input logic [2:0] sel, input err_events_t ev,
                                         input logic singleRail);
    logic hit;
    hit = 1'b0;
    unique case (sel)
      SRC_LINE_BIPOLAR_VIOLATION: hit = ev.lineBipolarViolation;
      SRC_LINE_EXCESS_ZEROS: hit = ev.lineExcessZeros;
      SRC_LBOTH: hit = ev.lineBipolarViolation | ev.lineExcessZeros;
      SRC_SYSTEM_BIPOLAR_VIOLATION: hit = ev.systemBipolarViolation & ~singleRail;
      SRC_SYSTEM_EXCESS_ZEROS: hit = ev.systemExcessZeros;
      SRC_SBOTH: hit = (ev.systemBipolarViolation | ev.systemExcessZeros) & ~singleRail;
      SRC_PATT: hit = ev.patternError;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction : errorSelected

  function automatic logic [JIT_W-1:0] peakOf(input logic [JIT_W-1:0] cur,
                                               input logic [JIT_W-1:0] smp);
    return (smp > cur) ? smp : cur;
  endfunction : peakOf

  logic errHit;
  logic countSnap;
  logic jitSnap;
  logic actCode;
  logic deactCode;
  logic holdGoal;
  logic autoRemoteEn;
  logic autoDigitalEn;
  logic remoteOn;
  logic digitalOn;
  logic jitOn;

  always_comb begin
    next_st = st;
    next_st.actSync = {st.actSync[0], activateCodeSeen};
    next_st.deactSync = {st.deactSync[0], deactivateCodeSeen};
    actCode = st.actSync[1];
    deactCode = st.deactSync[1];
    errHit = errorSelected(errCtrl.countSourceSelect, errEvents, txSingleRailNrz);
    // Snapshot source by mode; the edge memory tracks even in automatic mode
    countSnap = errCtrl.countUpdateMode ? secondTick
              : (errCtrl.countSnapshotTrigger & ~st.prevCountTrig);
    next_st.prevCountTrig = errCtrl.countSnapshotTrigger;
    if (countSnap) begin
      next_st.holding = st.counter;
      next_st.counter = errHit ? COUNT_ONE : COUNT_ZERO;
    end else if (errHit && st.counter != COUNT_ONES) begin
      next_st.counter = st.counter + COUNT_ONE;
    end
    // Set wins over the software clear
    if (secondTickIntClear) next_st.tickStatus = 1'b0;
    if (secondTick) next_st.tickStatus = 1'b1;
    if (countOverflowIntClear) next_st.ovfStatus = 1'b0;
    if (errHit && st.counter == COUNT_ONES) next_st.ovfStatus = 1'b1;
    next_st.intOut = (next_st.tickStatus & ~secondTickIntMask)
                   | (next_st.ovfStatus & ~countOverflowIntMask);

    // Automatic loop: code must be held continuously past the hold time
    autoRemoteEn = loopCtrl.autoLoopEnable & ~detectDirection;
    autoDigitalEn = loopCtrl.autoLoopEnable & detectDirection;
    holdGoal = (st.autoSt == AL_IDLE) ? actCode : deactCode;
    if (holdGoal && st.holdIsDeact == (st.autoSt != AL_IDLE)) begin
      if (st.holdCount != HOLD_LAST) next_st.holdCount = st.holdCount + 32'h0000_0001;
    end else begin
      next_st.holdCount = '0;
    end
    next_st.holdIsDeact = (st.autoSt != AL_IDLE);
    unique case (st.autoSt)
      AL_IDLE: begin
        if (loopCtrl.autoLoopEnable && holdGoal && st.holdCount == HOLD_LAST) begin
          next_st.autoSt = detectDirection ? AL_DIGITAL : AL_REMOTE;
          next_st.holdCount = '0;
        end
      end
      AL_REMOTE, AL_DIGITAL: begin
        if (!loopCtrl.autoLoopEnable || (holdGoal && st.holdCount == HOLD_LAST)) begin
          next_st.autoSt = AL_IDLE;
          next_st.holdCount = '0;
        end
      end
      default: next_st.autoSt = AL_IDLE;
    endcase
    // Registered copy so the status pin comes straight from a flop
    next_st.autoActive = (next_st.autoSt != AL_IDLE);
    // Direction is assumed stable while looped; the state keeps the entry direction
    remoteOn = loopCtrl.remoteLoopEnable
             | (autoRemoteEn & (st.autoSt == AL_REMOTE));
    digitalOn = loopCtrl.digitalLoopEnable
              | (autoDigitalEn & (st.autoSt == AL_DIGITAL));
    next_st.analog = loopCtrl.analogLoopEnable;
    next_st.remote = remoteOn & ~loopCtrl.analogLoopEnable;
    next_st.digital = digitalOn & ~loopCtrl.analogLoopEnable;

    next_st.path = '{default: 1'b0};
    next_st.path.rxAisAllowed = 1'b1;
    next_st.path.txAisAllowed = 1'b1;
    next_st.path.rxPatternWins = 1'b1;
    next_st.path.txPatternWins = 1'b1;
    if (loopCtrl.analogLoopEnable) begin
      next_st.path.rxLoopData = 1'b1;
      next_st.path.rxAisAllowed = 1'b0;
      next_st.path.txAisAllowed = 1'b0;
    end else begin
      if (next_st.remote) begin
        next_st.path.txLoopData = 1'b1;
        next_st.path.txClockIgnored = 1'b1;
        next_st.path.txAisAllowed = 1'b0;
      end
      if (next_st.digital) begin
        next_st.path.rxLoopData = 1'b1;
        next_st.path.rxAisAllowed = 1'b0;
      end
    end

    next_st.monActive = (monitorSourceSelect != MON_OFF) & isChannelZero;
    next_st.extMatch = next_st.monActive;

    // Jitter peaks; samples ignored unless channel 0 attenuator is running
    jitOn = isChannelZero & receiveJitterAttenuatorOn;
    next_st.jitBw = jitCtrl.jitterBandwidthSelect;
    jitSnap = jitCtrl.jitterPeriodMode ? secondTick
            : (jitCtrl.jitterSnapshotTrigger & ~st.prevJitTrig);
    next_st.prevJitTrig = jitCtrl.jitterSnapshotTrigger;
    if (jitOn && jitterSampleValid) begin
      if (jitterSampleNegative) next_st.negBuf = peakOf(st.negBuf, jitterSample);
      else next_st.posBuf = peakOf(st.posBuf, jitterSample);
    end
    if (jitSnap) begin
      next_st.posPeak = next_st.posBuf;
      next_st.negPeak = next_st.negBuf;
      next_st.posBuf = '0;
      next_st.negBuf = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
      st.autoSt <= AL_IDLE;
      st.path.rxAisAllowed <= 1'b1;
      st.path.txAisAllowed <= 1'b1;
      st.path.rxPatternWins <= 1'b1;
      st.path.txPatternWins <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign errorCount = st.holding;
  assign secondTickIntStatus = st.tickStatus;
  assign countOverflowIntStatus = st.ovfStatus;
  assign intOut = st.intOut;
  assign autoLoopState = st.autoActive;
  assign analogLoopActive = st.analog;
  assign remoteLoopActive = st.remote;
  assign digitalLoopActive = st.digital;
  assign pathSel = st.path;
  assign externalMatchForced = st.extMatch;
  assign monitorActive = st.monActive;
  assign jitterBandwidth = st.jitBw;
  assign jitterPosPeak = st.posPeak;
  assign jitterNegPeak = st.negPeak;

  property p_tick_sets_status;
    @(posedge clk) disable iff (!nrst) secondTick |=> secondTickIntStatus;
  endproperty
  a_tick_sets_status: assert property (p_tick_sets_status)
    else $error("tick status not set");

  property p_snap_auto;
    @(posedge clk) disable iff (!nrst)
      (secondTick && errCtrl.countUpdateMode) |=> (errorCount == $past(st.counter));
  endproperty
  a_snap_auto: assert property (p_snap_auto)
    else $error("auto snapshot wrong");

  property p_analog_blocks;
    @(posedge clk) disable iff (!nrst)
      loopCtrl.analogLoopEnable |=> (!remoteLoopActive && !digitalLoopActive);
  endproperty
  a_analog_blocks: assert property (p_analog_blocks)
    else $error("loop not blocked by analog");

  property p_ovf;
    @(posedge clk) disable iff (!nrst)
      (errHit && st.counter == COUNT_ONES) |=> countOverflowIntStatus;
  endproperty
  a_ovf: assert property (p_ovf)
    else $error("overflow not flagged");

  property p_manual_snap;
    @(posedge clk) disable iff (!nrst)
      (!errCtrl.countUpdateMode && errCtrl.countSnapshotTrigger && !st.prevCountTrig)
        |=> (errorCount == $past(st.counter));
  endproperty
  a_manual_snap: assert property (p_manual_snap)
    else $error("manual snapshot wrong");

  property p_remote_no_txais;
    @(posedge clk) disable iff (!nrst) remoteLoopActive |-> !pathSel.txAisAllowed;
  endproperty
  a_remote_no_txais: assert property (p_remote_no_txais)
    else $error("tx AIS allowed in remote loop");

  property p_monitor;
    @(posedge clk) disable iff (!nrst)
      (isChannelZero && monitorSourceSelect != MON_OFF) |=> externalMatchForced;
  endproperty
  a_monitor: assert property (p_monitor)
    else $error("external match not forced");

  property p_auto_off;
    @(posedge clk) disable iff (!nrst)
      (autoLoopState && !loopCtrl.autoLoopEnable) |=> !autoLoopState;
  endproperty
  a_auto_off: assert property (p_auto_off)
    else $error("auto loop not left");

  property p_digital_no_rxais;
    @(posedge clk) disable iff (!nrst) digitalLoopActive |-> !pathSel.rxAisAllowed;
  endproperty
  a_digital_no_rxais: assert property (p_digital_no_rxais)
    else $error("rx AIS allowed in digital loop");
endmodule : liu_channel_diag

/* File: tb/liu_far_side_model.sv */
// Purpose: Far side stand-in: error event pulses on all five sources, inband code levels, jitter samples
// Assumes: Bench calls the tasks; every change lands just after clk rises
// Notes: Sample bus carries inverted junk while not valid so stale data is never trusted
`timescale 1ns/1ps
module liu_far_side_model (
  input wire logic clk,
  output liu_diag_pkg::err_events_t errEvents,
  output logic activateCodeSeen,
  output logic deactivateCodeSeen,
  output logic jitterSampleValid,
  output logic jitterSampleNegative,
  output logic [liu_diag_pkg::JIT_W-1:0] jitterSample
);
  import liu_diag_pkg::*;

  initial begin
    errEvents = '0;
    activateCodeSeen = 1'h0;
    deactivateCodeSeen = 1'h0;
    jitterSampleValid = 1'h0;
    jitterSampleNegative = 1'h0;
    jitterSample = 16'h0000;
  end

  // Held high for n edges, one error counted per edge
  task automatic errBurst(input err_events_t m, input int n);
    @(posedge clk);
    errEvents <= m;
    repeat (n) @(posedge clk);
    errEvents <= '0;
  endtask : errBurst

  task automatic code(input logic a, input logic d);
    @(posedge clk);
    activateCodeSeen <= a;
    deactivateCodeSeen <= d;
  endtask : code

  task automatic jit(input logic neg, input logic [JIT_W-1:0] v);
    @(posedge clk);
    jitterSampleValid <= 1'h1;
    jitterSampleNegative <= neg;
    jitterSample <= v;
    @(posedge clk);
    jitterSampleValid <= 1'h0;
    jitterSampleNegative <= ~neg;
    jitterSample <= ~v;
  endtask : jit
endmodule : liu_far_side_model

/* File: tb/tb_top.sv */
// Purpose: Self-checking bench for the channel diagnostic block
// Assumes: Short second and code hold parameters keep the run small
// Notes: Overflow case runs 64K error cycles; only the mid-run reset follows it
`timescale 1ns/1ps
`define CHK(nm, e, a) begin cmpCount++; if ((a) !== (e)) begin failCount++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, a); end end
`define WAITON(c, n) begin for (k = 0; k < (n) && !(c); k++) begin @(posedge clk); #1; end \
  cmpCount++; if (!(c)) begin failCount++; $display("MISMATCH wait expected 1 seen 0"); \
  endSim(); end end
module tb_top;
  import liu_diag_pkg::*;
  localparam int SEC = 64;
  localparam int HOLD = 20;
  typedef struct packed {
    logic [2:0] src;
    logic nrz;
    logic [3:0] cnt;
    loop_ctrl_t lc;
    logic [2:0] act;
    logic [5:0] path;
  } row_t;
  row_t rows [11] = '{'{3'h0, 1'h0, 4'h1, 4'h0, 3'h0, 6'h3c}, '{3'h1, 1'h0, 4'h1, 4'h1, 3'h4, 6'h31},
    '{3'h2, 1'h0, 4'h2, 4'h2, 3'h2, 6'h3a}, '{3'h3, 1'h0, 4'h1, 4'h4, 3'h1, 6'h35},
    '{3'h4, 1'h0, 4'h1, 4'h7, 3'h4, 6'h31}, '{3'h5, 1'h0, 4'h2, 4'h0, 3'h0, 6'h3c},
    '{3'h6, 1'h0, 4'h1, 4'h1, 3'h4, 6'h31}, '{3'h7, 1'h0, 4'h0, 4'h2, 3'h2, 6'h3a},
    '{3'h3, 1'h1, 4'h0, 4'h4, 3'h1, 6'h35}, '{3'h5, 1'h1, 4'h0, 4'h7, 3'h4, 6'h31},
    '{3'h4, 1'h1, 4'h1, 4'h0, 3'h0, 6'h3c}};
  int failCount = 0;
  int cmpCount = 0;
  int k;
  logic clk, nrst, txSingleRailNrz, secondTickIntMask, secondTickIntClear;
  logic countOverflowIntMask, countOverflowIntClear, detectDirection;
  logic isChannelZero, receiveJitterAttenuatorOn;
  err_ctrl_t errCtrl;
  err_events_t errEvents;
  loop_ctrl_t loopCtrl;
  jit_ctrl_t jitCtrl;
  path_sel_t pathSel;
  logic [MON_W-1:0] monitorSourceSelect;
  logic [COUNT_W-1:0] errorCount;
  logic [JIT_W-1:0] jitterPosPeak, jitterNegPeak, jitterSample;
  logic activateCodeSeen, deactivateCodeSeen, jitterSampleValid, jitterSampleNegative;
  logic secondTickIntStatus, countOverflowIntStatus, intOut, autoLoopState;
  logic analogLoopActive, remoteLoopActive, digitalLoopActive;
  logic externalMatchForced, monitorActive, jitterBandwidth;

  liu_far_side_model i_liu_far_side_model (.clk, .errEvents, .activateCodeSeen,
    .deactivateCodeSeen, .jitterSampleValid, .jitterSampleNegative, .jitterSample);

  liu_channel_diag #(.SECOND_PERIOD(SEC), .AUTO_HOLD(HOLD)) i_liu_channel_diag (.clk, .nrst,
    .errCtrl, .errEvents, .txSingleRailNrz, .secondTickIntMask, .secondTickIntClear,
    .countOverflowIntMask, .countOverflowIntClear, .loopCtrl, .detectDirection,
    .activateCodeSeen, .deactivateCodeSeen, .monitorSourceSelect, .isChannelZero,
    .receiveJitterAttenuatorOn, .jitCtrl, .jitterSampleValid, .jitterSampleNegative,
    .jitterSample, .errorCount, .secondTickIntStatus, .countOverflowIntStatus, .intOut,
    .autoLoopState, .analogLoopActive, .remoteLoopActive, .digitalLoopActive, .pathSel,
    .externalMatchForced, .monitorActive, .jitterBandwidth, .jitterPosPeak, .jitterNegPeak);

  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end

  task automatic endSim();
    $display("checks %0d mismatches %0d", cmpCount, failCount);
    if (failCount == 0 && cmpCount > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : endSim

  // One rising edge snapshots both counter and jitter buffers
  task automatic snap();
    @(posedge clk);
    errCtrl.countSnapshotTrigger <= 1'h1;
    jitCtrl.jitterSnapshotTrigger <= 1'h1;
    @(posedge clk);
    errCtrl.countSnapshotTrigger <= 1'h0;
    jitCtrl.jitterSnapshotTrigger <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
  endtask : snap

  task automatic clearTick();
    @(posedge clk);
    secondTickIntClear <= 1'h1;
    @(posedge clk);
    secondTickIntClear <= 1'h0;
    @(posedge clk);
    #1;
  endtask : clearTick

  initial begin
    nrst = 1'h0;
    errCtrl = '0;
    loopCtrl = '0;
    jitCtrl = '0;
    txSingleRailNrz = 1'h0;
    secondTickIntMask = 1'h1;
    secondTickIntClear = 1'h0;
    countOverflowIntMask = 1'h0;
    countOverflowIntClear = 1'h0;
    detectDirection = 1'h0;
    monitorSourceSelect = 6'h00;
    isChannelZero = 1'h1;
    receiveJitterAttenuatorOn = 1'h1;
    repeat (16) @(posedge clk);
    #1;
    `CHK("reset", {16'h0000, 7'h5a, 32'h0000_0000, 10'h000}, {errorCount, pathSel,
      jitterPosPeak, jitterNegPeak, secondTickIntStatus, countOverflowIntStatus, intOut,
      autoLoopState, analogLoopActive, remoteLoopActive, digitalLoopActive,
      externalMatchForced, monitorActive, jitterBandwidth})
    @(posedge clk);
    nrst <= 1'h1;
    $display("test reset done");
    foreach (rows[i]) begin
      @(posedge clk);
      errCtrl.countSourceSelect <= rows[i].src;
      txSingleRailNrz <= rows[i].nrz;
      loopCtrl <= rows[i].lc;
      for (int b = 0; b < 5; b++) i_liu_far_side_model.errBurst(5'h01 << b, 1);
      snap();
      `CHK("count", 16'(rows[i].cnt), errorCount)
      `CHK("loops", rows[i].act, {analogLoopActive, remoteLoopActive, digitalLoopActive})
      `CHK("tx loop", rows[i].act[1], pathSel.txLoopData)
      `CHK("path", rows[i].path, {pathSel.rxPatternWins, pathSel.txPatternWins,
        pathSel.rxAisAllowed, pathSel.txAisAllowed, pathSel.txClockIgnored,
        pathSel.rxLoopData})
    end
    `CHK("tick masked", 2'h2, {secondTickIntStatus, intOut})
    $display("test table done");
    @(posedge clk);
    loopCtrl <= 4'h8;
    i_liu_far_side_model.code(1'h1, 1'h0);
    repeat (HOLD - 2) @(posedge clk);
    #1;
    `CHK("early entry", 1'h0, autoLoopState)
    `WAITON(autoLoopState === 1'h1, 12)
    @(posedge clk);
    #1;
    `CHK("auto remote", 2'h2, {remoteLoopActive, digitalLoopActive})
    i_liu_far_side_model.code(1'h0, 1'h1);
    repeat (HOLD - 2) @(posedge clk);
    #1;
    `CHK("early exit", 1'h1, autoLoopState)
    `WAITON(autoLoopState === 1'h0, 12)
    @(posedge clk);
    #1;
    `CHK("auto left", 1'h0, remoteLoopActive)
    i_liu_far_side_model.code(1'h0, 1'h0);
    @(posedge clk);
    detectDirection <= 1'h1;
    i_liu_far_side_model.code(1'h1, 1'h0);
    `WAITON(autoLoopState === 1'h1, HOLD + 12)
    @(posedge clk);
    #1;
    `CHK("auto digital", 2'h1, {remoteLoopActive, digitalLoopActive})
    @(posedge clk);
    loopCtrl <= 4'h0;
    repeat (3) @(posedge clk);
    #1;
    `CHK("auto off", 2'h0, {autoLoopState, digitalLoopActive})
    i_liu_far_side_model.code(1'h0, 1'h0);
    $display("test auto loop done");
    @(posedge clk);
    jitCtrl.jitterBandwidthSelect <= 1'h1;
    monitorSourceSelect <= 6'h05;
    i_liu_far_side_model.jit(1'h0, 16'h0005);
    i_liu_far_side_model.jit(1'h0, 16'h0009);
    i_liu_far_side_model.jit(1'h1, 16'h0007);
    i_liu_far_side_model.jit(1'h1, 16'h0003);
    snap();
    `CHK("peaks", 32'h0009_0007, {jitterPosPeak, jitterNegPeak})
    `CHK("bw mon", 3'h7, {jitterBandwidth, monitorActive, externalMatchForced})
    i_liu_far_side_model.jit(1'h0, 16'h0002);
    snap();
    `CHK("peaks cleared", 32'h0002_0000, {jitterPosPeak, jitterNegPeak})
    @(posedge clk);
    receiveJitterAttenuatorOn <= 1'h0;
    i_liu_far_side_model.jit(1'h0, 16'h001e);
    snap();
    `CHK("peaks off", 16'h0000, jitterPosPeak)
    $display("test jitter done");
    @(posedge clk);
    receiveJitterAttenuatorOn <= 1'h1;
    errCtrl.countUpdateMode <= 1'h1;
    errCtrl.countSourceSelect <= SRC_PATT;
    jitCtrl.jitterPeriodMode <= 1'h1;
    secondTickIntMask <= 1'h0;
    clearTick();
    `WAITON(secondTickIntStatus === 1'h1, SEC + 8)
    `CHK("tick int", 1'h1, intOut)
    clearTick();
    `CHK("tick clear", 2'h0, {secondTickIntStatus, intOut})
    i_liu_far_side_model.errBurst(5'h01, 3);
    i_liu_far_side_model.jit(1'h0, 16'h0004);
    `WAITON(secondTickIntStatus === 1'h1, SEC + 8)
    repeat (2) @(posedge clk);
    #1;
    `CHK("auto count", 16'h0003, errorCount)
    `CHK("auto peak", 16'h0004, jitterPosPeak)
    $display("test second done");
    @(posedge clk);
    errCtrl.countUpdateMode <= 1'h0;
    secondTickIntMask <= 1'h1;
    snap();
    i_liu_far_side_model.errBurst(5'h01, 65535);
    repeat (3) @(posedge clk);
    #1;
    `CHK("no overflow", 2'h0, {countOverflowIntStatus, intOut})
    i_liu_far_side_model.errBurst(5'h01, 1);
    repeat (3) @(posedge clk);
    #1;
    `CHK("overflow", 2'h3, {countOverflowIntStatus, intOut})
    snap();
    `CHK("saturated", 16'hffff, errorCount)
    @(posedge clk);
    countOverflowIntMask <= 1'h1;
    repeat (2) @(posedge clk);
    #1;
    `CHK("ovf masked", 2'h2, {countOverflowIntStatus, intOut})
    @(posedge clk);
    countOverflowIntClear <= 1'h1;
    @(posedge clk);
    countOverflowIntClear <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("ovf clear", 1'h0, countOverflowIntStatus)
    $display("test overflow done");
    // Mid-run reset must clear sticky status and restart the second timer
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    #1;
    `CHK("mid reset", {16'h0000, 7'h5a, 32'h0000_0000, 10'h000}, {errorCount, pathSel,
      jitterPosPeak, jitterNegPeak, secondTickIntStatus, countOverflowIntStatus, intOut,
      autoLoopState, analogLoopActive, remoteLoopActive, digitalLoopActive,
      externalMatchForced, monitorActive, jitterBandwidth})
    @(posedge clk);
    nrst <= 1'h1;
    repeat (SEC - 8) @(posedge clk);
    #1;
    `CHK("timer restart", 1'h0, secondTickIntStatus)
    `WAITON(secondTickIntStatus === 1'h1, 16)
    $display("test mid reset done");
    endSim();
  end
endmodule : tb_top
